// file: spi_slave_consts.vh
`ifndef SPI_SLAVE_CONSTS_VH
`define SPI_SLAVE_CONSTS_VH
// protocol mode codes
`define MODE_FULL_DUPLEX 3'h0
`define MODE_HALF_4PIN 3'h1
`define MODE_HALF_3PIN 3'h2
`define MODE_UNMANAGED 3'h3
`define MODE_LEGACY 3'h4
// status byte bit positions, msb first on the wire (position 1 = bit 7)
`define STAT_TXE_BIT 3
`define STAT_RXF_BIT 2
`define STAT_ACK_BIT 1
`define STAT_DRIVE_MASK 8'h0E
// command byte fields
`define CMD_DIR_BIT 4
`define CMD_ADDR_MSB 7
`define CMD_ADDR_LSB 5
// legacy frame lengths in serial clocks
`define LEG_CMD_BITS 4'h3
`define LEG_DATA_END 4'hB
`define LEG_STAT_END 4'hC
`endif

// file: multimode_spi_slave.v
`timescale 1ns/10ps
`include "spi_slave_consts.vh"
// Functional notes
// (R1) full duplex: status out during command byte
// (R2) full duplex write streams, status per byte
// (R3) full duplex read alternates data and status
// (R4) command: three address bits then direction bit
// (R5) direction one reads, zero writes
// (R6) status position five is transmit empty flag
// (R7) status position six is receive full flag
// (R8) status position seven acknowledges own address
// (R9) 4-pin half duplex shares mosi line
// (R10) 4-pin half duplex status on miso
// (R11) 4-pin write streams until select drops
// (R12) 4-pin read turns mosi to output
// (R13) 3-pin status bytes on shared mosi
// (R14) 3-pin write: status after each data byte
// (R15) 3-pin read: all data slave to master
// (R16) unmanaged: cpu byte loaded into shifter
// (R17) unmanaged: exchange, received byte to register
// (R18) legacy: active-high select, three-bit command
// (R19) legacy write: status bit zero stored
// (R20) legacy read: data then new/old bit
// (R21) legacy address bit selects status byte
// (R22) legacy direction one reads, zero writes
// (R23) select release aborts, returns to idle
// (R24) runs on system clock, paced by sclk
// (R25) mode changes only while deselected
// (R26) deselected: outputs undriven, counter cleared
module multimode_spi_slave #(
  parameter [2:0] SLAVE_CODE = 3'h0
) (
  input wire clk_sys,
  input wire rst_b,
  input wire [2:0] mode_cfg,
  input wire [7:0] tx_data,
  input wire tx_load,
  output wire tx_load_ready,
  output reg [7:0] rx_data_q,
  output reg rx_valid_q,
  input wire rx_read,
  input wire port0_serial_clock_in,
  input wire port0_select_n,
  input wire port0_mosi_in,
  output wire port0_mosi_out,
  output wire port0_mosi_oe,
  output wire port0_miso_out,
  output wire port0_miso_oe,
  output wire [2:0] active_mode,
  output wire tx_nothing_pending_flag,
  output wire rx_holding_full_flag
);

// ----------------------------------------------------------------
// input synchronisers
// ----------------------------------------------------------------
// three stages; a change counts once stages two and three agree
reg [2:0] sck_s_q;
reg [2:0] sel_s_q;
reg [2:0] mosi_s_q;
reg sck_f_q;
reg sel_f_q;
reg mosi_f_q;
wire sck_f_d = (sck_s_q[1] == sck_s_q[2]) ? sck_s_q[2] : sck_f_q;
wire sel_f_d = (sel_s_q[1] == sel_s_q[2]) ? sel_s_q[2] : sel_f_q;
wire mosi_f_d = (mosi_s_q[1] == mosi_s_q[2]) ? mosi_s_q[2] : mosi_f_q;

always @(posedge clk_sys or negedge rst_b) begin // (R24)
  if (!rst_b) begin
    sck_s_q <= 3'h0;
    sel_s_q <= 3'h7;
    mosi_s_q <= 3'h0;
    sck_f_q <= 1'b0;
    sel_f_q <= 1'b1;
    mosi_f_q <= 1'b0;
  end else begin
    sck_s_q <= {sck_s_q[1:0], port0_serial_clock_in};
    sel_s_q <= {sel_s_q[1:0], port0_select_n};
    mosi_s_q <= {mosi_s_q[1:0], port0_mosi_in};
    sck_f_q <= sck_f_d;
    sel_f_q <= sel_f_d;
    mosi_f_q <= mosi_f_d;
  end
end

wire sck_rise = sck_f_d & ~sck_f_q;
wire sck_fall = ~sck_f_d & sck_f_q;

// ----------------------------------------------------------------
// mode latch and selection
// ----------------------------------------------------------------
reg [2:0] mode_q;
wire legacy = (mode_q == `MODE_LEGACY);
// legacy select is active high on the same pin
wire selected = legacy ? sel_f_q : ~sel_f_q; // (R18)
wire sel_now = legacy ? sel_f_d : ~sel_f_d;

always @(posedge clk_sys or negedge rst_b) begin
  if (!rst_b) begin
    mode_q <= `MODE_FULL_DUPLEX;
  end else if (!selected && !sel_now) begin
    mode_q <= mode_cfg; // (R25)
  end
end
assign active_mode = mode_q;

// ----------------------------------------------------------------
// transmit holding and receive holding
// ----------------------------------------------------------------
reg [7:0] tx_hold_q;
reg tx_full_q;
reg tx_take;
reg rx_put;
reg [7:0] rx_byte;
assign tx_load_ready = ~tx_full_q;
assign tx_nothing_pending_flag = ~tx_full_q;
assign rx_holding_full_flag = rx_valid_q;

always @(posedge clk_sys or negedge rst_b) begin
  if (!rst_b) begin
    tx_hold_q <= 8'h00;
    tx_full_q <= 1'b0;
    rx_data_q <= 8'h00;
    rx_valid_q <= 1'b0;
  end else begin
    if (tx_load && !tx_full_q) begin
      tx_hold_q <= tx_data;
      tx_full_q <= 1'b1;
    end else if (tx_take) begin
      tx_full_q <= 1'b0;
    end
    // a new byte arriving with the read wins over the clear
    if (rx_put) begin
      rx_data_q <= rx_byte;
      rx_valid_q <= 1'b1;
    end else if (rx_read) begin
      rx_valid_q <= 1'b0;
    end
  end
end

// ----------------------------------------------------------------
// serial engine
// ----------------------------------------------------------------
// phase: 0 command byte, 1 status byte, 2 data byte
localparam PH_CMD = 2'h0;
localparam PH_STAT = 2'h1;
localparam PH_DATA = 2'h2;
reg [1:0] phase_q;
reg [3:0] bit_q;
reg [7:0] rx_sh_q;
reg [7:0] tx_sh_q;
reg [7:0] stat_sh_q;
reg dir_rd_q;
reg ack_q;
reg leg_addr_q;
reg leg_ok_q;
reg out_q;
reg aux_q;
wire [7:0] rx_next = {rx_sh_q[6:0], mosi_f_q};
wire [3:0] bit_inc = bit_q + 4'h1;
wire addr_hit = (rx_next[`CMD_ADDR_MSB:`CMD_ADDR_LSB] == SLAVE_CODE);
wire [7:0] stat_byte = {4'h0, tx_full_q ? 1'b0 : 1'b1, rx_valid_q, // (R6)(R7)
                        ack_q, 1'b0}; // (R8)
wire [7:0] leg_stat = {6'h00, tx_full_q ? 1'b0 : 1'b1, rx_valid_q};
// address bits arrive ahead of the ack slot, so the command byte's own
// status can already acknowledge
wire cmd_hit = (rx_sh_q[5:3] == SLAVE_CODE);
wire stat_bit = (phase_q == PH_CMD && bit_q == 4'h6) ? cmd_hit
                : stat_sh_q[7]; // (R8)

always @* begin
  tx_take = 1'b0;
  rx_put = 1'b0;
  rx_byte = rx_next;
  if (selected && sck_rise && !legacy && bit_q == 4'h7) begin
    if (mode_q == `MODE_UNMANAGED) begin
      rx_put = 1'b1; // (R17)
    end else if (phase_q == PH_DATA && !dir_rd_q && ack_q) begin
      rx_put = ~rx_valid_q; // (R2)(R11)(R14)
    end
  end
  if (selected && sck_rise && legacy && bit_q == `LEG_DATA_END - 4'h1
      && !leg_addr_q) begin
    if (!dir_rd_q) begin
      rx_put = ~rx_valid_q; // (R19)
    end
  end
  if (selected && sck_rise && legacy && bit_q == `LEG_CMD_BITS - 4'h1
      && rx_next[0] == 1'b0 && rx_next[1]) begin
    tx_take = tx_full_q; // (R20)
  end
  if (selected && sck_fall && !legacy && bit_q == 4'h0 && tx_full_q) begin
    if (mode_q == `MODE_UNMANAGED) begin
      tx_take = 1'b1; // (R16)
    end else if (phase_q == PH_DATA && dir_rd_q && ack_q) begin
      tx_take = 1'b1; // (R3)
    end
  end
end

// drive enable of the serial byte: whether this slot belongs to the
// slave, used for the 3-pin mosi line
reg slave_slot;
always @* begin
  slave_slot = 1'b0;
  case (phase_q)
    PH_CMD: slave_slot = 1'b0;
    PH_STAT: slave_slot = 1'b1;
    PH_DATA: slave_slot = dir_rd_q;
    default: slave_slot = 1'b0;
  endcase
end

always @(posedge clk_sys or negedge rst_b) begin
  if (!rst_b) begin
    phase_q <= PH_CMD;
    bit_q <= 4'h0;
    rx_sh_q <= 8'h00;
    tx_sh_q <= 8'h00;
    stat_sh_q <= 8'h00;
    dir_rd_q <= 1'b0;
    ack_q <= 1'b0;
    leg_addr_q <= 1'b0;
    leg_ok_q <= 1'b0;
    out_q <= 1'b0;
    aux_q <= 1'b0;
  end else if (!selected) begin
    phase_q <= PH_CMD; // (R23)(R26)
    bit_q <= 4'h0;
    ack_q <= 1'b0;
    stat_sh_q <= stat_byte;
    tx_sh_q <= tx_hold_q;
    out_q <= stat_byte[7];
    aux_q <= stat_byte[7];
  end else if (legacy) begin
    if (sck_rise) begin
      rx_sh_q <= rx_next;
      bit_q <= (bit_q == `LEG_STAT_END) ? 4'h0 : bit_inc;
      if (bit_q == `LEG_CMD_BITS - 4'h1) begin
        dir_rd_q <= rx_next[1]; // (R22)
        leg_addr_q <= rx_next[0]; // (R21)
        leg_ok_q <= tx_full_q;
        tx_sh_q <= rx_next[0] ? leg_stat : tx_hold_q;
        out_q <= rx_next[0] ? leg_stat[7] : tx_hold_q[7];
      end else if (bit_q >= `LEG_CMD_BITS && bit_q < `LEG_DATA_END) begin
        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
        out_q <= tx_sh_q[6];
        if (bit_q == `LEG_DATA_END - 4'h1) begin
          // status bit: zero means success / new data
          if (dir_rd_q) begin
            out_q <= leg_addr_q ? 1'b0 : ~leg_ok_q; // (R20)
          end else begin
            out_q <= leg_addr_q ? 1'b1 : rx_valid_q; // (R19)
          end
        end
      end
    end
  end else if (sck_fall) begin
    // cpha=1: outputs change on the leading edge of each bit
    if (bit_q == 4'h0) begin
      if (mode_q == `MODE_UNMANAGED) begin
        out_q <= tx_full_q ? tx_hold_q[7] : tx_sh_q[7];
        tx_sh_q <= tx_full_q ? {tx_hold_q[6:0], 1'b0} : tx_sh_q;
      end else if (phase_q == PH_DATA && dir_rd_q) begin
        out_q <= tx_hold_q[7];
        tx_sh_q <= {tx_hold_q[6:0], 1'b0};
      end else begin
        stat_sh_q <= {stat_byte[6:0], 1'b0};
        aux_q <= stat_byte[7];
        out_q <= stat_byte[7];
      end
    end else begin
      out_q <= (phase_q == PH_DATA && dir_rd_q) || legacy ||
               mode_q == `MODE_UNMANAGED ? tx_sh_q[7] : stat_bit;
      aux_q <= stat_bit;
      tx_sh_q <= {tx_sh_q[6:0], 1'b0};
      stat_sh_q <= {stat_sh_q[6:0], 1'b0};
    end
  end else if (sck_rise) begin
    rx_sh_q <= rx_next;
    bit_q <= (bit_q == 4'h7) ? 4'h0 : bit_inc;
    if (bit_q == 4'h7 && mode_q != `MODE_UNMANAGED) begin
      case (phase_q)
        PH_CMD: begin
          dir_rd_q <= rx_next[`CMD_DIR_BIT]; // (R4)(R5)
          ack_q <= addr_hit; // (R8)
          // 3-pin sends status on the line after the command
          phase_q <= (mode_q == `MODE_HALF_3PIN) ? PH_STAT : PH_DATA;
        end
        PH_STAT: phase_q <= PH_DATA;
        PH_DATA: begin
          // 3-pin write gets status between data bytes;
          // full duplex read alternates status and data
          if (mode_q == `MODE_HALF_3PIN && !dir_rd_q) begin
            phase_q <= PH_STAT; // (R14)
          end else if (mode_q == `MODE_FULL_DUPLEX && dir_rd_q) begin
            phase_q <= PH_STAT; // (R3)
          end else begin
            phase_q <= PH_DATA; // (R15)(R12)
          end
        end
        default: phase_q <= PH_CMD;
      endcase
    end
  end
end

// ----------------------------------------------------------------
// pin drive
// ----------------------------------------------------------------
// status bit positions outside the flag field stay undriven
wire [7:0] stat_pos_vec = `STAT_DRIVE_MASK >> (4'h7 - bit_q);
wire stat_pos_on = stat_pos_vec[0];
// every full duplex slot that is not read data carries status
wire fd_stat_on = ~(phase_q == PH_DATA && dir_rd_q) & stat_pos_on; // (R2)
reg miso_en;
reg mosi_en;
always @* begin
  miso_en = 1'b0;
  mosi_en = 1'b0;
  if (selected) begin
    case (mode_q)
      `MODE_FULL_DUPLEX: miso_en = dir_rd_q && phase_q == PH_DATA ? 1'b1
                                   : fd_stat_on; // (R1)
      `MODE_HALF_4PIN: begin
        miso_en = ~(phase_q == PH_DATA && dir_rd_q) & stat_pos_on; // (R10)
        mosi_en = phase_q == PH_DATA && dir_rd_q; // (R9)(R12)
      end
      `MODE_HALF_3PIN: mosi_en = phase_q == PH_STAT ? stat_pos_on
                                 : slave_slot; // (R13)
      `MODE_UNMANAGED: miso_en = 1'b1; // (R17)
      `MODE_LEGACY: miso_en = bit_q >= `LEG_CMD_BITS;
      default: miso_en = 1'b0;
    endcase
  end
end

assign port0_miso_out = (mode_q == `MODE_HALF_4PIN && !(phase_q == PH_DATA
                         && dir_rd_q)) ? aux_q : out_q;
assign port0_miso_oe = miso_en; // (R26)
assign port0_mosi_out = out_q;
assign port0_mosi_oe = mosi_en;

endmodule

// file: spi_master_model.sv
`timescale 1ns/10ps
module spi_master_model (
  input wire clk_sys,
  input wire mosi_out,
  input wire mosi_oe,
  input wire miso_out,
  input wire miso_oe,
  output logic sclk,
  output logic sel_n,
  output wire mosi_line
);
  logic drv_q = 1'b0;
  logic bit_q = 1'b0;
  logic mosi_last_q = 1'b0;
  logic miso_last_q = 1'b0;
  wire miso_line;
  // ---------------------------------
  // line levels and shifting
  // ---------------------------------
  // a released line toggles each cycle so a stale bit never reads as good
  assign mosi_line = drv_q ? bit_q
                     : (mosi_oe ? mosi_out : ~mosi_last_q);
  assign miso_line = miso_oe ? miso_out : ~miso_last_q;
  always @(posedge clk_sys) begin
    mosi_last_q <= mosi_line;
    miso_last_q <= miso_line;
  end
  initial begin
    sclk = 1'b1;
    sel_n = 1'b1;
  end
  task automatic sel(input logic v);
    @(posedge clk_sys);
    sel_n <= v;
    drv_q <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  // sclk idles high; bits change on the fall, sampled late in the high phase
  task automatic shift(input int n, input logic [15:0] v, input logic drv,
      output logic [15:0] mi, output logic [15:0] mo);
    int i;
    mi = 16'h0000;
    mo = 16'h0000;
    for (i = n - 1; i >= 0; i--) begin
      sclk <= 1'b0;
      drv_q <= drv;
      bit_q <= v[i];
      repeat (4) @(posedge clk_sys);
      sclk <= 1'b1;
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      mi = {mi[14:0], miso_line};
      mo = {mo[14:0], mosi_line};
      @(posedge clk_sys);
    end
  endtask
endmodule

// file: multimode_spi_slave_props.sv
`timescale 1ns/10ps
`include "spi_slave_consts.vh"
module multimode_spi_slave_props (
  input wire clk_sys,
  input wire rst_b,
  input wire [2:0] active_mode,
  input wire port0_select_n,
  input wire port0_mosi_oe,
  input wire port0_miso_oe,
  input wire tx_load,
  input wire tx_load_ready,
  input wire tx_nothing_pending_flag,
  input wire rx_valid_q,
  input wire rx_read,
  input wire rx_holding_full_flag
);
  // ---------------------------------
  // port checks
  // ---------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // legacy select is active high, all other modes active low
  wire leg = active_mode == `MODE_LEGACY;
  wire off = leg ? !port0_select_n : port0_select_n;
  a_idle_pins_off: assert property (off[*6] |->
      !port0_miso_oe && !port0_mosi_oe)
    else $error("serial output driven while deselected");
  a_mosi_turn_mode: assert property (port0_mosi_oe |->
      active_mode == `MODE_HALF_4PIN || active_mode == `MODE_HALF_3PIN)
    else $error("mosi driven outside half duplex");
  a_three_pin_miso: assert property (
      active_mode == `MODE_HALF_3PIN |-> !port0_miso_oe)
    else $error("miso driven in three pin mode");
  a_mode_hold: assert property (!off[*5] |-> $stable(active_mode))
    else $error("mode changed while selected");
  a_rx_level: assert property (rx_valid_q && !rx_read |=> rx_valid_q)
    else $error("received byte lost before read");
  a_rx_clear: assert property (off[*6] ##0 rx_read |=> !rx_valid_q)
    else $error("receive flag not cleared by read");
  a_rxf_flag: assert property (off[*6] ##0 !rx_holding_full_flag |=>
      !rx_holding_full_flag)
    else $error("receive full flag set while deselected");
  a_txe_flag: assert property (off[*6] ##0 !tx_nothing_pending_flag |=>
      !tx_nothing_pending_flag)
    else $error("pending byte lost while deselected");
  a_tx_pending: assert property (tx_load && tx_load_ready && off &&
      active_mode != `MODE_UNMANAGED |=> !tx_nothing_pending_flag)
    else $error("loaded byte not pending");
  cover property (port0_mosi_oe);
  cover property (rx_valid_q && rx_read);
  cover property (leg && !off);
endmodule
bind multimode_spi_slave multimode_spi_slave_props chk_u (
  .clk_sys(clk_sys), .rst_b(rst_b), .active_mode(active_mode),
  .port0_select_n(port0_select_n), .port0_mosi_oe(port0_mosi_oe),
  .port0_miso_oe(port0_miso_oe), .tx_load(tx_load),
  .tx_load_ready(tx_load_ready),
  .tx_nothing_pending_flag(tx_nothing_pending_flag),
  .rx_valid_q(rx_valid_q), .rx_read(rx_read),
  .rx_holding_full_flag(rx_holding_full_flag));

// file: multimode_spi_slave_tb.sv
`timescale 1ns/10ps
`include "spi_slave_consts.vh"
module multimode_spi_slave_tb;
  logic clk_sys;
  logic rst_b;
  logic tx_load;
  logic rx_read;
  logic [2:0] mode_cfg;
  logic [7:0] tx_data;
  logic [15:0] mi;
  logic [15:0] mo;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  wire sclk;
  wire sel_n;
  wire mosi_line;
  wire mosi_out;
  wire mosi_oe;
  wire miso_out;
  wire miso_oe;
  wire tx_load_ready;
  wire rx_valid_q;
  wire txe_flag;
  wire rxf_flag;
  wire [7:0] rx_data_q;
  wire [2:0] active_mode;
  multimode_spi_slave dut_u (.clk_sys(clk_sys), .rst_b(rst_b),
    .mode_cfg(mode_cfg), .tx_data(tx_data), .tx_load(tx_load),
    .tx_load_ready(tx_load_ready), .rx_data_q(rx_data_q),
    .rx_valid_q(rx_valid_q), .rx_read(rx_read),
    .port0_serial_clock_in(sclk), .port0_select_n(sel_n),
    .port0_mosi_in(mosi_line), .port0_mosi_out(mosi_out),
    .port0_mosi_oe(mosi_oe), .port0_miso_out(miso_out),
    .port0_miso_oe(miso_oe), .active_mode(active_mode),
    .tx_nothing_pending_flag(txe_flag), .rx_holding_full_flag(rxf_flag));
  spi_master_model mst_u (.clk_sys(clk_sys), .mosi_out(mosi_out),
    .mosi_oe(mosi_oe), .miso_out(miso_out), .miso_oe(miso_oe),
    .sclk(sclk), .sel_n(sel_n), .mosi_line(mosi_line));
  // ---------------------------------
  // helpers
  // ---------------------------------
  initial begin
    clk_sys = 1'b0;
    rst_b = 1'b0;
    tx_load = 1'b0;
    rx_read = 1'b0;
    mode_cfg = `MODE_FULL_DUPLEX;
    tx_data = 8'h00;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic print_verdict;
    if (error_cnt == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // the whole run needs well under a tenth of this
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      print_verdict;
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic load(input logic [7:0] b);
    @(posedge clk_sys);
    tx_data <= b;
    tx_load <= 1'b1;
    @(posedge clk_sys);
    tx_load <= 1'b0;
  endtask
  task automatic take;
    @(posedge clk_sys);
    rx_read <= 1'b1;
    @(posedge clk_sys);
    rx_read <= 1'b0;
  endtask
  task automatic mode(input logic [2:0] m);
    @(posedge clk_sys);
    mode_cfg <= m;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic xb(input logic [15:0] v, input logic drv);
    mst_u.shift(8, v, drv, mi, mo);
  endtask
  // ---------------------------------
  // scenarios
  // ---------------------------------
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk_sys);
    check({15'h0000, txe_flag}, 16'h0001);
    load(8'h81);
    mst_u.sel(1'b0);
    xb(16'h0010, 1'b1);
    check(mi & 16'h000E, 16'h0002);
    xb(16'h0000, 1'b1);
    check(mi[7:0], 8'h81);
    xb(16'h0000, 1'b1);
    check(mi & 16'h000E, 16'h000A);
    mst_u.sel(1'b1);
    mst_u.sel(1'b0);
    mst_u.shift(3, 16'h0007, 1'b1, mi, mo);
    mst_u.sel(1'b1);
    mst_u.sel(1'b0);
    xb(16'h0000, 1'b1);
    check(mi & 16'h000E, 16'h000A);
    xb(16'h00A5, 1'b1);
    check(mi & 16'h000E, 16'h000A);
    xb(16'h005A, 1'b1);
    check(mi & 16'h000E, 16'h000E);
    mst_u.sel(1'b1);
    check({8'h00, rx_data_q}, 16'h00A5);
    take;
    mst_u.sel(1'b0);
    xb(16'h00B0, 1'b1);
    check(mi & 16'h0002, 16'h0000);
    mst_u.sel(1'b1);
    mode(`MODE_UNMANAGED);
    load(8'h3C);
    mst_u.sel(1'b0);
    xb(16'h00C3, 1'b1);
    mst_u.sel(1'b1);
    check(mi[7:0], 8'h3C);
    check({8'h00, rx_data_q}, 16'h00C3);
    take;
    mode(`MODE_HALF_4PIN);
    load(8'h5A);
    mst_u.sel(1'b0);
    xb(16'h0010, 1'b1);
    check(mi & 16'h000E, 16'h0002);
    xb(16'h0000, 1'b0);
    check(mo[7:0], 8'h5A);
    mst_u.sel(1'b1);
    mst_u.sel(1'b0);
    xb(16'h0000, 1'b1);
    xb(16'h0069, 1'b1);
    mst_u.sel(1'b1);
    check({8'h00, rx_data_q}, 16'h0069);
    take;
    mode(`MODE_HALF_3PIN);
    mst_u.sel(1'b0);
    xb(16'h0000, 1'b1);
    xb(16'h0000, 1'b0);
    check(mo & 16'h000E, 16'h000A);
    xb(16'h0096, 1'b1);
    xb(16'h0000, 1'b0);
    check(mo & 16'h000E, 16'h000E);
    mst_u.sel(1'b1);
    check({8'h00, rx_data_q}, 16'h0096);
    take;
    load(8'h4B);
    mst_u.sel(1'b0);
    xb(16'h0010, 1'b1);
    xb(16'h0000, 1'b0);
    check(mo & 16'h000E, 16'h0002);
    xb(16'h0000, 1'b0);
    check(mo[7:0], 8'h4B);
    mst_u.sel(1'b1);
    mode(`MODE_LEGACY);
    mst_u.sel(1'b0);
    mst_u.sel(1'b1);
    mst_u.shift(13, 16'h131C, 1'b1, mi, mo);
    mst_u.sel(1'b0);
    check({15'h0000, mi[1]}, 16'h0000);
    check({8'h00, rx_data_q}, 16'h00C7);
    mst_u.sel(1'b1);
    mst_u.shift(13, 16'h1044, 1'b1, mi, mo);
    mst_u.sel(1'b0);
    check({15'h0000, mi[1]}, 16'h0001);
    check({8'h00, rx_data_q}, 16'h00C7);
    load(8'hE1);
    mst_u.sel(1'b1);
    mst_u.shift(13, 16'h1800, 1'b1, mi, mo);
    mst_u.sel(1'b0);
    check(mi & 16'h03FE, 16'h0384);
    mst_u.sel(1'b1);
    mst_u.shift(13, 16'h1800, 1'b1, mi, mo);
    mst_u.sel(1'b0);
    check(mi & 16'h0002, 16'h0002);
    mst_u.sel(1'b1);
    mst_u.shift(13, 16'h1C00, 1'b1, mi, mo);
    mst_u.sel(1'b0);
    check(mi & 16'h03FE, 16'h000C);
    print_verdict;
  end
endmodule
